// [design/led_pwm_ramp_executor.sv]
// PWM ramp executor for one program engine: numeric and variable ramps
`timescale 1ns/10ps
module led_pwm_ramp_executor
  import led_ramp_pkg::*;
#(
  parameter int ENGINE_IDX = 0
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction from the sequencer
  input wire logic instrStart,
  input wire logic instrIsVar,
  input wire logic [15:0] instrWord,
  output logic instrDone,
  output logic rampBusy,
  // Variable load and direct PWM set
  input wire logic loadValid,
  input wire logic [1:0] loadSel,
  input wire logic [7:0] loadData,
  input wire logic pwmSetValid,
  input wire logic [7:0] pwmSetValue,
  // Host register access
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // LED test converter
  input wire logic [7:0] adcResult,
  // PWM towards mapped LEDs
  output logic [7:0] effPwm,
  output logic [7:0] ledPwm
);
  import led_ramp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] logCurve(input logic [7:0] lin);
    logic [15:0] sq;
    sq = 16'(lin) * 16'(lin) + 16'h00FF;
    logCurve = sq[15:8];
  endfunction : logCurve

  function automatic logic [STEP_W-1:0] stepLenOf(input logic [STEP_W-1:0] t);
    stepLenOf = (t == '0) ? STEP_W'(1) : t;
  endfunction : stepLenOf

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic tickFast;
  logic tickSlow;
  logic baseTick;
  logic stepPulse;
  logic [7:0] varA_r;
  logic [7:0] varB_r;
  logic [7:0] varC_r;
  logic [7:0] varD;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] ctrl3;
  logic [7:0] engCtrl;
  logic [7:0] varDSrc;
  logic [7:0] stepVar;
  logic [7:0] incVar;
  logic newPrescale;
  logic newSign;
  logic [STEP_W-1:0] newStep;
  logic [7:0] newInc;
  ramp_state_t state_r;
  ramp_state_t state_nxt;
  logic prescale_r;
  logic sign_r;
  logic waitMode_r;
  logic [STEP_W-1:0] stepLen_r;
  logic [STEP_W-1:0] tickCnt_r;
  logic [7:0] stepsLeft_r;
  logic [7:0] effPwm_r;
  logic [7:0] effPwm_nxt;
  logic [STEP_W-1:0] seenTicks_r;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  ramp_timebase u_timebase (
    .sys_clk(sys_clk),
    .rst(rst),
    .tickFast(tickFast),
    .tickSlow(tickSlow)
  );

  ramp_reg_bank u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .regWrEn(regWrEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .varA(varA_r),
    .adcResult(adcResult),
    .ctrl1(ctrl1),
    .ctrl2(ctrl2),
    .ctrl3(ctrl3),
    .varD(varD)
  );

  // ----------------------------------------------------------------
  // Variables and operand selection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      varA_r <= VARIABLE_RESET;
      varB_r <= VARIABLE_RESET;
      varC_r <= VARIABLE_RESET;
    end
    else if (loadValid)
    begin
      case (loadSel)
        SEL_VAR_A: varA_r <= loadData;
        SEL_VAR_B: varB_r <= loadData;
        SEL_VAR_C: varC_r <= loadData;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (ENGINE_IDX)
      1: engCtrl = ctrl2;
      2: engCtrl = ctrl3;
      default: engCtrl = ctrl1;
    endcase
  end

  assign varDSrc = engCtrl[CTRL_D_FROM_ADC_BIT] ? adcResult : varD;

  function automatic logic [7:0] pickVar(input logic [1:0] sel, input logic [7:0] a,
                                         input logic [7:0] b, input logic [7:0] c,
                                         input logic [7:0] d);
    case (sel)
      SEL_VAR_A: pickVar = a;
      SEL_VAR_B: pickVar = b;
      SEL_VAR_C: pickVar = c;
      default: pickVar = d;
    endcase
  endfunction : pickVar

  assign stepVar = pickVar(instrWord[VAR_STEP_SEL_MSB:VAR_STEP_SEL_LSB],
                           varA_r, varB_r, varC_r, varDSrc);
  assign incVar = pickVar(instrWord[VAR_INC_SEL_MSB:0], varA_r, varB_r, varC_r, varDSrc);

  always_comb
  begin
    if (instrIsVar)
    begin
      newPrescale = instrWord[VAR_PRESCALE_BIT];
      newSign = instrWord[VAR_SIGN_BIT];
      newStep = stepVar[STEP_W-1:0];
      newInc = incVar;
    end
    else
    begin
      newPrescale = instrWord[NUM_PRESCALE_BIT];
      newSign = instrWord[NUM_SIGN_BIT];
      newStep = instrWord[NUM_STEP_MSB:NUM_STEP_LSB];
      newInc = instrWord[NUM_INC_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Ramp sequencing
  // ----------------------------------------------------------------
  assign baseTick = prescale_r ? tickSlow : tickFast;
  assign stepPulse = (state_r != ST_IDLE) && baseTick && (tickCnt_r == stepLen_r - 1'b1);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (instrStart)
          state_nxt = (newInc <= 8'h01) ? ST_LAST : ST_RUN;
      ST_RUN:
        if (stepPulse && (stepsLeft_r == 8'h02))
          state_nxt = ST_LAST;
      ST_LAST:
        if (stepPulse)
          state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Operands captured once; later variable writes do not reach a running ramp
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prescale_r <= 1'b0;
      sign_r <= 1'b0;
      waitMode_r <= 1'b0;
      stepLen_r <= STEP_W'(1);
    end
    else if ((state_r == ST_IDLE) && instrStart)
    begin
      prescale_r <= newPrescale;
      sign_r <= newSign;
      waitMode_r <= (newInc == 8'h00);
      stepLen_r <= stepLenOf(newStep);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stepsLeft_r <= 8'h00;
    else if ((state_r == ST_IDLE) && instrStart)
      stepsLeft_r <= (newInc == 8'h00) ? 8'h01 : newInc;
    else if (stepPulse)
      stepsLeft_r <= stepsLeft_r - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      tickCnt_r <= '0;
    else if (state_r == ST_IDLE)
      tickCnt_r <= '0;
    else if (stepPulse)
      tickCnt_r <= '0;
    else if (baseTick)
      tickCnt_r <= tickCnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Effective PWM value
  // ----------------------------------------------------------------
  always_comb
  begin
    effPwm_nxt = effPwm_r;
    if (state_r == ST_IDLE)
    begin
      // A start in the same cycle wins over a direct set
      if (pwmSetValid && !instrStart)
        effPwm_nxt = pwmSetValue;
    end
    else if (stepPulse && !waitMode_r)
    begin
      if (!sign_r && (effPwm_r != 8'hFF))
        effPwm_nxt = effPwm_r + 1'b1;
      else if (sign_r && (effPwm_r != 8'h00))
        effPwm_nxt = effPwm_r - 1'b1;
      else
        effPwm_nxt = effPwm_r;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      effPwm_r <= PWM_RESET;
    else
      effPwm_r <= effPwm_nxt;
  end

  // Curve applied to the next value ahead of the register so LEDs see one clean change per step
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ledPwm <= PWM_RESET;
    else
      ledPwm <= engCtrl[CTRL_LOG_EN_BIT] ? logCurve(effPwm_nxt) : effPwm_nxt;
  end

  assign effPwm = effPwm_r;
  assign instrDone = (state_r == ST_LAST) && stepPulse;
  assign rampBusy = (state_r != ST_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst || (state_r == ST_IDLE) || stepPulse)
      seenTicks_r <= '0;
    else if (baseTick)
      seenTicks_r <= seenTicks_r + 1'b1;
  end

  property p_start_value;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && instrStart) |=> (effPwm_r == $past(effPwm_r));
  endproperty
  a_start_value: assert property (p_start_value) else $error("ramp start moved PWM");

  property p_step_one;
    @(posedge sys_clk) disable iff (rst)
      (stepPulse && !waitMode_r && !sign_r && effPwm_r != 8'hFF)
        |=> (effPwm_r == $past(effPwm_r) + 8'h01);
  endproperty
  a_step_one: assert property (p_step_one) else $error("up step not one unit");

  property p_step_down;
    @(posedge sys_clk) disable iff (rst)
      (stepPulse && !waitMode_r && sign_r && effPwm_r != 8'h00)
        |=> (effPwm_r == $past(effPwm_r) - 8'h01);
  endproperty
  a_step_down: assert property (p_step_down) else $error("down step wrong");

  property p_prescale;
    @(posedge sys_clk) disable iff (rst)
      rampBusy |-> (baseTick == (prescale_r ? tickSlow : tickFast)) && (!tickSlow || tickFast);
  endproperty
  a_prescale: assert property (p_prescale) else $error("base tick source wrong");

  property p_step_len;
    @(posedge sys_clk) disable iff (rst)
      stepPulse |-> (baseTick && (seenTicks_r + STEP_W'(1) == stepLen_r));
  endproperty
  a_step_len: assert property (p_step_len) else $error("step length wrong");

  property p_step_zero;
    @(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && instrStart && newStep == '0) |=> (stepLen_r == STEP_W'(1));
  endproperty
  a_step_zero: assert property (p_step_zero) else $error("zero step time not one cycle");

  property p_saturate;
    @(posedge sys_clk) disable iff (rst)
      (stepPulse && ((!sign_r && effPwm_r == 8'hFF) || (sign_r && effPwm_r == 8'h00)))
        |=> $stable(effPwm_r) && (rampBusy || ($past(state_r) == ST_LAST));
  endproperty
  a_saturate: assert property (p_saturate) else $error("saturation not held");

  property p_wait;
    @(posedge sys_clk) disable iff (rst)
      (rampBusy && waitMode_r) |=> $stable(effPwm_r);
  endproperty
  a_wait: assert property (p_wait) else $error("wait changed PWM");

  property p_capture;
    @(posedge sys_clk) disable iff (rst)
      (rampBusy && $past(rampBusy)) |-> $stable(stepLen_r) && $stable(sign_r);
  endproperty
  a_capture: assert property (p_capture) else $error("operands changed mid ramp");

  property p_done;
    @(posedge sys_clk) disable iff (rst)
      instrDone |-> (stepsLeft_r == 8'h01) ##1 (!rampBusy && stepsLeft_r == 8'h00);
  endproperty
  a_done: assert property (p_done) else $error("finished before last step");

  property p_hold;
    @(posedge sys_clk) disable iff (rst)
      (rampBusy && !stepPulse) |=> $stable(effPwm_r);
  endproperty
  a_hold: assert property (p_hold) else $error("PWM changed between steps");

  property p_curve;
    @(posedge sys_clk) disable iff (rst)
      $stable(engCtrl) |-> ledPwm == (engCtrl[CTRL_LOG_EN_BIT] ?
        logCurve(effPwm_r) : effPwm_r);
  endproperty
  a_curve: assert property (p_curve) else $error("curve output wrong");

endmodule : led_pwm_ramp_executor

// [design/led_ramp_pkg.sv]
// Constants, field layouts and types shared by the PWM ramp executor files
package led_ramp_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int MASTER_CLK_HZ = 32_768;
  localparam int PRESCALE_LO_DIV = 16;
  localparam int PRESCALE_HI_DIV = 512;
  localparam int ACC_W = 24;
  localparam int DIV_W = 9;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ENGINE1_CONTROL_OFFSET = 8'h06;
  localparam logic [7:0] ENGINE2_CONTROL_OFFSET = 8'h07;
  localparam logic [7:0] ENGINE3_CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] GLOBAL_VARIABLE_D_OFFSET = 8'h3C;
  localparam logic [7:0] LOCAL_VARIABLE_A_OFFSET = 8'h3D;
  localparam logic [7:0] LED_TEST_CONVERTER_RESULT_OFFSET = 8'h42;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_LOG_EN_BIT = 5;
  localparam int CTRL_D_FROM_ADC_BIT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] VARIABLE_RESET = 8'h00;
  localparam logic [7:0] PWM_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int NUM_PRESCALE_BIT = 14;
  localparam int NUM_STEP_MSB = 13;
  localparam int NUM_STEP_LSB = 9;
  localparam int NUM_SIGN_BIT = 8;
  localparam int NUM_INC_MSB = 7;
  localparam int VAR_PRESCALE_BIT = 5;
  localparam int VAR_SIGN_BIT = 4;
  localparam int VAR_STEP_SEL_MSB = 3;
  localparam int VAR_STEP_SEL_LSB = 2;
  localparam int VAR_INC_SEL_MSB = 1;
  localparam int STEP_W = 5;

  // ----------------------------------------------------------------
  // Variable selector codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_VAR_A = 2'h0;
  localparam logic [1:0] SEL_VAR_B = 2'h1;
  localparam logic [1:0] SEL_VAR_C = 2'h2;
  localparam logic [1:0] SEL_VAR_D = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_LAST = 2'b11
  } ramp_state_t;

endpackage : led_ramp_pkg

// [design/ramp_timebase.sv]
// Step base ticks derived from the system clock via a 32768 Hz master tick
`timescale 1ns/10ps
module ramp_timebase
  import led_ramp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Base cycle enables
  output logic tickFast,
  output logic tickSlow
);
  import led_ramp_pkg::*;

  logic [ACC_W-1:0] phase_r;
  logic [DIV_W-1:0] div_r;
  logic masterTick;

  // Fractional accumulator: exact long-term 32768 Hz with no second clock
  assign masterTick = ({1'b0, phase_r} + ACC_W'(MASTER_CLK_HZ)) >= (ACC_W+1)'(SYS_CLK_HZ);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      phase_r <= '0;
    else if (masterTick)
      phase_r <= phase_r + ACC_W'(MASTER_CLK_HZ) - ACC_W'(SYS_CLK_HZ);
    else
      phase_r <= phase_r + ACC_W'(MASTER_CLK_HZ);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      div_r <= '0;
    else if (masterTick)
      div_r <= div_r + 1'b1;
  end

  assign tickFast = masterTick && (div_r[3:0] == 4'(PRESCALE_LO_DIV - 1));
  assign tickSlow = masterTick && (div_r == DIV_W'(PRESCALE_HI_DIV - 1));

endmodule : ramp_timebase

// [design/ramp_reg_bank.sv]
// Host-visible control and variable registers used by the ramp executor
`timescale 1ns/10ps
module ramp_reg_bank
  import led_ramp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host register access
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Register contents
  input wire logic [7:0] varA,
  input wire logic [7:0] adcResult,
  output logic [7:0] ctrl1,
  output logic [7:0] ctrl2,
  output logic [7:0] ctrl3,
  output logic [7:0] varD
);
  import led_ramp_pkg::*;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl1 <= CONTROL_RESET;
      ctrl2 <= CONTROL_RESET;
      ctrl3 <= CONTROL_RESET;
      varD <= VARIABLE_RESET;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        ENGINE1_CONTROL_OFFSET: ctrl1 <= regWrData;
        ENGINE2_CONTROL_OFFSET: ctrl2 <= regWrData;
        ENGINE3_CONTROL_OFFSET: ctrl3 <= regWrData;
        GLOBAL_VARIABLE_D_OFFSET: varD <= regWrData;
        default: ;
      endcase
    end
  end

  // Read data registered; unmapped offsets give 0, writes to read-only ones are ignored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      regRdData <= 8'h00;
    else
    begin
      case (regAddr)
        ENGINE1_CONTROL_OFFSET: regRdData <= ctrl1;
        ENGINE2_CONTROL_OFFSET: regRdData <= ctrl2;
        ENGINE3_CONTROL_OFFSET: regRdData <= ctrl3;
        GLOBAL_VARIABLE_D_OFFSET: regRdData <= varD;
        LOCAL_VARIABLE_A_OFFSET: regRdData <= varA;
        LED_TEST_CONVERTER_RESULT_OFFSET: regRdData <= adcResult;
        default: regRdData <= 8'h00;
      endcase
    end
  end

endmodule : ramp_reg_bank

// [tb/ramp_sequencer_model.sv]
// Sequencer model issuing ramp, load and direct PWM requests
`timescale 1ns/10ps
module ramp_sequencer_model
(
  // Clock
  input wire logic sys_clk,
  // Requests towards the executor
  output logic instrStart,
  output logic instrIsVar,
  output logic [15:0] instrWord,
  output logic loadValid,
  output logic [1:0] loadSel,
  output logic [7:0] loadData,
  output logic pwmSetValid,
  output logic [7:0] pwmSetValue
);
  initial
  begin
    instrStart = 1'b0;
    instrIsVar = 1'b0;
    instrWord = 16'h0000;
    loadValid = 1'b0;
    loadSel = 2'h0;
    loadData = 8'h00;
    pwmSetValid = 1'b0;
    pwmSetValue = 8'h00;
  end

  // Released fields show the inverse so stale values never look valid
  task automatic issue(input logic isVar, input logic [15:0] word);
    @(negedge sys_clk);
    instrStart = 1'b1;
    instrIsVar = isVar;
    instrWord = word;
    @(negedge sys_clk);
    instrStart = 1'b0;
    instrIsVar = ~isVar;
    instrWord = ~word;
  endtask : issue

  // Only path that sets the local variables
  task automatic load(input logic [1:0] sel, input logic [7:0] data);
    @(negedge sys_clk);
    loadValid = 1'b1;
    loadSel = sel;
    loadData = data;
    @(negedge sys_clk);
    loadValid = 1'b0;
    loadData = ~data;
  endtask : load

  task automatic setPwm(input logic [7:0] v);
    @(negedge sys_clk);
    pwmSetValid = 1'b1;
    pwmSetValue = v;
    @(negedge sys_clk);
    pwmSetValid = 1'b0;
    pwmSetValue = ~v;
  endtask : setPwm
endmodule : ramp_sequencer_model

// [tb/led_pwm_ramp_executor_bench.sv]
// Self-checking bench for the PWM ramp executor
`timescale 1ns/10ps
module led_pwm_ramp_executor_bench;
  import led_ramp_pkg::*;
  // Sys cycles per prescale-0 base tick
  localparam int TICK = 4883;
  localparam int LIMIT = 80000;
  logic sys_clk, rst, regWrEn, instrStart, instrIsVar, instrDone, rampBusy;
  logic loadValid, pwmSetValid, logOn, monOn;
  logic [15:0] instrWord;
  logic [1:0] loadSel;
  logic [7:0] loadData, pwmSetValue, regAddr, regWrData, regRdData;
  logic [7:0] adcResult, effPwm, ledPwm, lastPwm, cur, d;
  logic [7:0] expQ[$];
  int mismatches, total_checks, cycles, seed;

  ramp_sequencer_model u_ramp_sequencer_model (.sys_clk(sys_clk), .instrStart(instrStart),
    .instrIsVar(instrIsVar), .instrWord(instrWord), .loadValid(loadValid),
    .loadSel(loadSel), .loadData(loadData), .pwmSetValid(pwmSetValid),
    .pwmSetValue(pwmSetValue));

  led_pwm_ramp_executor #(.ENGINE_IDX(0)) u_led_pwm_ramp_executor (.sys_clk(sys_clk),
    .rst(rst), .instrStart(instrStart), .instrIsVar(instrIsVar), .instrWord(instrWord),
    .instrDone(instrDone), .rampBusy(rampBusy), .loadValid(loadValid),
    .loadSel(loadSel), .loadData(loadData), .pwmSetValid(pwmSetValid),
    .pwmSetValue(pwmSetValue), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .adcResult(adcResult),
    .effPwm(effPwm), .ledPwm(ledPwm));

  always #50 sys_clk = ~sys_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [7:0] curve(input logic [7:0] x);
    logic [15:0] s;
    s = x * x + 16'h00FF;
    return logOn ? s[15:8] : x;
  endfunction : curve

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(negedge sys_clk)
  begin
    logic [7:0] e;
    if (monOn && effPwm !== lastPwm)
    begin
      lastPwm = effPwm;
      e = (expQ.size() > 0) ? expQ.pop_front() : ~effPwm;
      check("effPwm", e, effPwm);
      check("ledPwm", curve(e), ledPwm);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regWrData = ~v;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regAddr = a;
    @(negedge sys_clk);
    check("regRdData", v, regRdData);
  endtask : rd

  task automatic setp(input logic [7:0] v);
    expQ.push_back(v);
    cur = v;
    u_ramp_sequencer_model.setPwm(v);
  endtask : setp

  // Runs one ramp; t is its length in base ticks, stray adds refused requests
  task automatic run(input logic isVar, input logic [15:0] w, input logic up, input int n,
    input int t, input logic stray);
    int c0;
    repeat (n)
    begin
      d = up ? ((cur == 8'hFF) ? cur : cur + 8'h01) : ((cur == 8'h00) ? cur : cur - 8'h01);
      if (d != cur)
        expQ.push_back(d);
      cur = d;
    end
    c0 = cycles;
    u_ramp_sequencer_model.issue(isVar, w);
    check("rampBusy", 1'b1, rampBusy);
    if (stray)
    begin
      u_ramp_sequencer_model.issue(1'b0, 16'h00FF);
      u_ramp_sequencer_model.setPwm(8'h00);
    end
    while (instrDone !== 1'b1 && cycles - c0 < (t + 2) * TICK)
      @(negedge sys_clk);
    check("duration", 1'b1, cycles - c0 >= (t - 1) * 4880 && cycles - c0 <= (t + 1) * 4890);
    @(negedge sys_clk);
    check("rampBusy", 1'b0, rampBusy);
    repeat (2) @(negedge sys_clk);
    check("pending", 16'h0000, 16'(expQ.size()));
    check("effPwm final", cur, effPwm);
    $display("ramp %h done", w);
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    adcResult = 8'h02;
    logOn = 1'b0;
    monOn = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    seed = 4256;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    check("effPwm reset", PWM_RESET, effPwm);
    check("ledPwm reset", PWM_RESET, ledPwm);
    check("rampBusy reset", 1'b0, rampBusy);
    rd(ENGINE1_CONTROL_OFFSET, CONTROL_RESET);
    rd(GLOBAL_VARIABLE_D_OFFSET, VARIABLE_RESET);
    lastPwm = effPwm;
    cur = effPwm;
    monOn = 1'b1;
    $display("reset test done");
    d = 8'($random(seed));
    wr(GLOBAL_VARIABLE_D_OFFSET, d);
    rd(GLOBAL_VARIABLE_D_OFFSET, d);
    wr(LED_TEST_CONVERTER_RESULT_OFFSET, 8'hFD);
    rd(LED_TEST_CONVERTER_RESULT_OFFSET, 8'h02);
    rd(8'h77, 8'h00);
    wr(ENGINE1_CONTROL_OFFSET, 8'h20);
    rd(ENGINE1_CONTROL_OFFSET, 8'h20);
    logOn = 1'b1;
    $display("register test done");
    // Saturation at the top with step time zero, stray requests refused
    setp(8'hFE);
    run(1'b0, 16'h0003, 1'b1, 3, 3, 1'b1);
    wr(ENGINE1_CONTROL_OFFSET, 8'h00);
    logOn = 1'b0;
    run(1'b0, 16'h0502, 1'b0, 2, 4, 1'b0);
    run(1'b0, 16'h0200, 1'b0, 0, 1, 1'b0);
    u_ramp_sequencer_model.load(SEL_VAR_A, 8'h03);
    u_ramp_sequencer_model.load(SEL_VAR_B, 8'h01);
    u_ramp_sequencer_model.load(SEL_VAR_C, 8'h01);
    fork
      run(1'b1, 16'h0014, 1'b0, 3, 3, 1'b0);
      begin
        repeat (20) @(negedge sys_clk);
        u_ramp_sequencer_model.load(SEL_VAR_A, 8'h32);
      end
    join
    rd(LOCAL_VARIABLE_A_OFFSET, 8'h32);
    wr(ENGINE1_CONTROL_OFFSET, 8'h10);
    run(1'b1, 16'h000B, 1'b1, 2, 2, 1'b0);
    test_done();
  end
endmodule : led_pwm_ramp_executor_bench
